// >>> logic/clock_gear_pkg.sv
// Function
// - Warm-up counts 2^8, 2^14 or 2^16 oscillator cycles for codes 01, 10, 11.
// - Writing one to bit 2 restarts warm-up; bit reads one until done.
// - Source select bit 3: zero routes high clock, one routes low clock.
// - Gear field divides high clock by 1, 2, 4, 8 or 16.
// - Gear resets to 100; system clock is pre-divider clock halved.
// - New gear is in force once a later write cycle completes.
// - Prescaler taps divide pre-divider or fc/16 clock by 2 and 4.
// - Prescaler source code 00 picks pre-divider, 10 picks fc/16.
// - Multiplier output runs at four times the high oscillator clock.
// - Reset stops the multiplier until software writes its control field.
// - Bit 5 of multiplier control reads one until lock-up ends.
// - Action codes: 00 stop, 01 run pass, 10 multiplied, 11 oscillator.
// - Oscillator drive bits reset to one; zero selects reduced drive.
// - External input bit makes output pin constantly high; resets to zero.
// - Protected register writes are blocked while protection is on.
// - A blocked write raises the protection violation request.
// - Key pairs 5AH/A5H then A5H/5AH toggle protection; off after reset.
package clock_gear_pkg;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_OSC   = 8'he0;
    localparam logic [7:0] OFS_GEAR  = 8'he1;
    localparam logic [7:0] OFS_HALT  = 8'he2;
    localparam logic [7:0] OFS_NOISE = 8'he3;
    localparam logic [7:0] OFS_KEY1  = 8'he4;
    localparam logic [7:0] OFS_KEY2  = 8'he5;
    localparam logic [7:0] OFS_MULT  = 8'he8;
    localparam logic [7:0] OFS_TRIM  = 8'he9;
    // --------------------------------------------------------------
    // Reset values and masks
    // --------------------------------------------------------------
    localparam logic [7:0] OSC_RST    = 8'he0;
    localparam logic [3:0] GEAR_RST   = 4'h4;
    localparam logic [7:0] HALT_RST   = 8'h2c;
    localparam logic [7:0] HALT_MASK  = 8'hbf;
    localparam logic [7:0] NOISE_RST  = 8'h03;
    localparam logic [7:0] NOISE_MASK = 8'h77;
    localparam logic [7:0] OSC_MASK   = 8'hfb;
    localparam logic [7:0] KEY_A      = 8'h5a;
    localparam logic [7:0] KEY_B      = 8'ha5;
    // --------------------------------------------------------------
    // Field positions and codes
    // --------------------------------------------------------------
    localparam int WARM_BIT    = 2;
    localparam int HIGH_EN_BIT = 7;
    localparam int LOW_EN_BIT  = 6;
    localparam int SRC_BIT     = 3;
    localparam int LOCK_BIT    = 5;
    localparam int LOCKLEN_BIT = 4;
    localparam int EXT_BIT     = 2;
    localparam int DRVH_BIT    = 1;
    localparam int DRVL_BIT    = 0;
    localparam logic [1:0] PRCK_FPH  = 2'h0;
    localparam logic [1:0] PRCK_FC16 = 2'h2;
    localparam logic [1:0] WARM_N8   = 2'h1;
    localparam logic [1:0] WARM_N14  = 2'h2;
    localparam logic [1:0] ACT_STOP  = 2'h0;
    localparam logic [1:0] ACT_PASS  = 2'h1;
    localparam logic [1:0] ACT_MULT  = 2'h2;
    localparam logic [1:0] ACT_OSC   = 2'h3;
    // --------------------------------------------------------------
    // Counts
    // --------------------------------------------------------------
    localparam logic [16:0] WARM_CNT8  = 17'h00100;
    localparam logic [16:0] WARM_CNT14 = 17'h04000;
    localparam logic [16:0] WARM_CNT16 = 17'h10000;
    localparam logic [12:0] LOCK_CNT12 = 13'h1000;
    localparam logic [12:0] LOCK_CNT10 = 13'h0400;
    localparam int          MULT_SHIFT = 2;
    localparam logic [2:0]  GEAR_MAX   = 3'h4;

    typedef enum logic [1:0] {KEY_IDLE, KEY_S1, KEY_S2, KEY_S3} key_state_type;
endpackage

// >>> logic/mult_link_if.sv
interface mult_link_if;
    logic ce;
    logic osc_tick;
    logic run;
    logic lock_short;
    logic start;
    logic lock_busy;
    logic mult_tick;
    modport ctrl (output ce, osc_tick, run, lock_short, start, input lock_busy, mult_tick);
    modport mult (input ce, osc_tick, run, lock_short, start, output lock_busy, mult_tick);
endinterface

// >>> logic/clock_multiplier.sv
module clock_multiplier
    import clock_gear_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    mult_link_if.mult link
);
    logic [12:0] lock_cnt_q;
    logic        busy_q;
    logic [7:0]  per_cnt_q;
    logic [7:0]  period_q;
    logic [7:0]  phase_q;
    logic        tick_q;
    logic [12:0] lock_target;
    logic [7:0]  quarter;

    assign lock_target = link.lock_short ? LOCK_CNT10 : LOCK_CNT12;
    assign quarter     = period_q >> MULT_SHIFT;

    // --------------------------------------------------------------
    // Lock-up interval
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            lock_cnt_q <= 13'h0000;
            busy_q     <= 1'b0;
        end else if (link.ce) begin
            if (link.start) begin
                lock_cnt_q <= 13'h0000;
                busy_q     <= 1'b1;
            end else if (!link.run) begin
                busy_q <= 1'b0;
            end else if (busy_q && link.osc_tick) begin
                lock_cnt_q <= lock_cnt_q + 13'h0001;
                if (lock_cnt_q + 13'h0001 == lock_target) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Times-four tick: measure oscillator period, emit every quarter
    // --------------------------------------------------------------
    // Oscillator period must be 4 to 255 clocks for four ticks to fit
    always_ff @(posedge clock) begin
        if (srst) begin
            per_cnt_q <= 8'h00;
            period_q  <= 8'h00;
            phase_q   <= 8'h00;
            tick_q    <= 1'b0;
        end else if (link.ce) begin
            tick_q <= 1'b0;
            if (!link.run) begin
                per_cnt_q <= 8'h00;
                phase_q   <= 8'h00;
            end else if (link.osc_tick) begin
                period_q  <= per_cnt_q + 8'h01;
                per_cnt_q <= 8'h00;
                phase_q   <= 8'h00;
                tick_q    <= 1'b1;
            end else begin
                if (per_cnt_q != 8'hff) begin
                    per_cnt_q <= per_cnt_q + 8'h01;
                end
                if (quarter != 8'h00 && phase_q + 8'h01 >= quarter) begin
                    phase_q <= 8'h00;
                    tick_q  <= 1'b1;
                end else begin
                    phase_q <= phase_q + 8'h01;
                end
            end
        end
    end

    assign link.lock_busy = busy_q;
    assign link.mult_tick = tick_q;
endmodule

// >>> logic/clock_gear_doubler_protect.sv
// The address-and-strobe port is this design's own decision.
module clock_gear_doubler_protect
    import clock_gear_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       high_osc_in,
    input  wire logic       low_osc_in,
    output logic            sys_clock_en,
    output logic            pre_divider_tick,
    output logic            prescaler_tap_half,
    output logic            prescaler_tap_quarter,
    output logic            high_osc_enable,
    output logic            low_osc_enable,
    output logic            high_osc_drive,
    output logic            low_osc_drive,
    output logic            osc_output_pin,
    output logic            protection_violation_irq
);
    mult_link_if link ();

    logic [1:0]    sync1_q;
    logic [1:0]    sync2_q;
    logic [1:0]    prev_q;
    logic [1:0]    osc_tick;
    logic [7:0]    osc_q;
    logic [3:0]    src_gear_q;
    logic [2:0]    gear_act_q;
    logic          gear_pend_q;
    logic [7:0]    halt_q;
    logic [7:0]    noise_q;
    logic [1:0]    act_q;
    logic          lock_short_q;
    logic [7:0]    trim_q;
    logic          protect_q;
    key_state_type key_q;
    logic          irq_q;
    logic          warm_busy_q;
    logic [16:0]   warm_cnt_q;
    logic [3:0]    gear_cnt_q;
    logic [3:0]    fc16_cnt_q;
    logic          half_q;
    logic [1:0]    tap_cnt_q;
    logic          pre_q;
    logic          sys_q;
    logic          tap_h_q;
    logic          tap_q_q;
    logic [7:0]    rdata_q;
    logic          blocked;
    logic          wr_ok;
    logic          guarded;
    logic          use_mult;
    logic          base_tick;
    logic [3:0]    gear_mask;
    logic          boundary;
    logic          pre_d;
    logic          fc16_tick;
    logic          psrc;
    logic          warm_tick;
    logic [16:0]   warm_target;

    // --------------------------------------------------------------
    // Pin synchronisers and edge ticks
    // --------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (srst) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                prev_q[i]  <= 1'b0;
            end else if (ce) begin
                sync1_q[i] <= (i == 0) ? high_osc_in : low_osc_in;
                sync2_q[i] <= sync1_q[i];
                prev_q[i]  <= sync2_q[i];
            end
        end
        assign osc_tick[i] = sync2_q[i] & ~prev_q[i];
    end

    // --------------------------------------------------------------
    // Write protection and key sequence
    // --------------------------------------------------------------
    assign guarded = (addr == OFS_OSC) || (addr == OFS_GEAR) || (addr == OFS_HALT) ||
                     (addr == OFS_NOISE) || (addr == OFS_MULT) || (addr == OFS_TRIM);
    assign blocked = wr_en && protect_q && guarded;
    assign wr_ok   = wr_en && !blocked;

    // Any write outside the exact key order restarts the sequence
    always_ff @(posedge clock) begin
        if (srst) begin
            key_q     <= KEY_IDLE;
            protect_q <= 1'b0;
        end else if (ce && wr_en) begin
            case (key_q)
                KEY_IDLE: key_q <= (addr == OFS_KEY1 && wdata == KEY_A) ? KEY_S1 : KEY_IDLE;
                KEY_S1:   key_q <= (addr == OFS_KEY2 && wdata == KEY_B) ? KEY_S2 : KEY_IDLE;
                KEY_S2:   key_q <= (addr == OFS_KEY1 && wdata == KEY_B) ? KEY_S3 : KEY_IDLE;
                KEY_S3: begin
                    key_q <= KEY_IDLE;
                    if (addr == OFS_KEY2 && wdata == KEY_A) begin
                        protect_q <= !protect_q;
                    end
                end
                default: key_q <= KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= blocked;
        end
    end

    // --------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            osc_q      <= OSC_RST;
            src_gear_q <= GEAR_RST;
            halt_q     <= HALT_RST;
            noise_q    <= NOISE_RST;
            trim_q     <= 8'h00;
        end else if (ce && wr_ok) begin
            case (addr)
                OFS_OSC:   osc_q <= wdata & OSC_MASK;
                OFS_GEAR:  src_gear_q <= wdata[3:0];
                OFS_HALT:  halt_q <= wdata & HALT_MASK;
                OFS_NOISE: noise_q <= wdata & NOISE_MASK;
                OFS_TRIM:  trim_q <= wdata;
                default:   trim_q <= trim_q;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            act_q        <= ACT_STOP;
            lock_short_q <= 1'b0;
        end else if (ce && wr_ok && addr == OFS_MULT) begin
            act_q        <= wdata[7:6];
            lock_short_q <= wdata[LOCKLEN_BIT];
        end
    end

    assign link.ce         = ce;
    assign link.osc_tick   = osc_tick[0];
    assign link.run        = act_q != ACT_STOP;
    assign link.lock_short = lock_short_q;
    assign link.start      = wr_ok && addr == OFS_MULT && act_q == ACT_STOP && wdata[7:6] != ACT_STOP;

    clock_multiplier u_mult (
        .clock (clock),
        .srst  (srst),
        .link  (link.mult)
    );

    // --------------------------------------------------------------
    // Warm-up timer
    // --------------------------------------------------------------
    // Counts the oscillator not currently feeding the system
    assign warm_tick   = src_gear_q[SRC_BIT] ? osc_tick[0] : osc_tick[1];
    assign warm_target = (halt_q[5:4] == WARM_N14) ? WARM_CNT14 :
                         (halt_q[5:4] == WARM_N8)  ? WARM_CNT8 : WARM_CNT16;

    always_ff @(posedge clock) begin
        if (srst) begin
            warm_cnt_q  <= 17'h00000;
            warm_busy_q <= 1'b0;
        end else if (ce) begin
            if (wr_ok && addr == OFS_OSC && wdata[WARM_BIT]) begin
                warm_cnt_q  <= 17'h00000;
                warm_busy_q <= 1'b1;
            end else if (warm_busy_q && warm_tick) begin
                warm_cnt_q <= warm_cnt_q + 17'h00001;
                if (warm_cnt_q + 17'h00001 == warm_target) begin
                    warm_busy_q <= 1'b0;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Gear, pre-divider and system clock
    // --------------------------------------------------------------
    assign use_mult  = act_q == ACT_MULT;
    assign base_tick = use_mult ? link.mult_tick : osc_tick[0];
    assign gear_mask = 4'((5'h01 << gear_act_q) - 5'h01);
    assign boundary  = base_tick && ((gear_cnt_q & gear_mask) == gear_mask);
    assign pre_d     = src_gear_q[SRC_BIT] ? osc_tick[1] : boundary;

    // Deferred gear waits for a divider boundary or the next write
    always_ff @(posedge clock) begin
        if (srst) begin
            gear_act_q  <= GEAR_MAX;
            gear_pend_q <= 1'b0;
        end else if (ce) begin
            if (wr_ok && addr == OFS_GEAR) begin
                gear_pend_q <= 1'b1;
            end else if (gear_pend_q && (boundary || wr_en)) begin
                gear_act_q  <= (src_gear_q[2:0] > GEAR_MAX) ? GEAR_MAX : src_gear_q[2:0];
                gear_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            gear_cnt_q <= 4'h0;
            fc16_cnt_q <= 4'h0;
            half_q     <= 1'b0;
            pre_q      <= 1'b0;
            sys_q      <= 1'b0;
        end else if (ce) begin
            if (base_tick) begin
                gear_cnt_q <= gear_cnt_q + 4'h1;
            end
            if (osc_tick[0]) begin
                fc16_cnt_q <= fc16_cnt_q + 4'h1;
            end
            if (pre_d) begin
                half_q <= !half_q;
            end
            pre_q <= pre_d;
            sys_q <= pre_d && half_q;
        end
    end

    // --------------------------------------------------------------
    // Prescaler taps
    // --------------------------------------------------------------
    assign fc16_tick = osc_tick[0] && fc16_cnt_q == 4'hf;
    assign psrc      = (osc_q[1:0] == PRCK_FC16) ? fc16_tick :
                       (osc_q[1:0] == PRCK_FPH)  ? pre_d : 1'b0;

    always_ff @(posedge clock) begin
        if (srst) begin
            tap_cnt_q <= 2'h0;
            tap_h_q   <= 1'b0;
            tap_q_q   <= 1'b0;
        end else if (ce) begin
            if (psrc) begin
                tap_cnt_q <= tap_cnt_q + 2'h1;
            end
            tap_h_q <= psrc && tap_cnt_q[0];
            tap_q_q <= psrc && tap_cnt_q == 2'h3;
        end
    end

    // --------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (ce && rd_en) begin
            case (addr)
                OFS_OSC:   rdata_q <= {osc_q[7:3], warm_busy_q, osc_q[1:0]};
                OFS_GEAR:  rdata_q <= {4'h0, src_gear_q};
                OFS_HALT:  rdata_q <= halt_q;
                OFS_NOISE: rdata_q <= {protect_q, noise_q[6:0]};
                OFS_MULT:  rdata_q <= {act_q, link.lock_busy, lock_short_q, 4'h0};
                OFS_TRIM:  rdata_q <= trim_q;
                default:   rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata                    = rdata_q;
    assign sys_clock_en             = sys_q;
    assign pre_divider_tick         = pre_q;
    assign prescaler_tap_half       = tap_h_q;
    assign prescaler_tap_quarter    = tap_q_q;
    assign high_osc_enable          = osc_q[HIGH_EN_BIT];
    assign low_osc_enable           = osc_q[LOW_EN_BIT];
    assign high_osc_drive           = noise_q[DRVH_BIT];
    assign low_osc_drive            = noise_q[DRVL_BIT];
    assign osc_output_pin           = noise_q[EXT_BIT] | ~sync2_q[0];
    assign protection_violation_irq = irq_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Key writes separated by one idle bus cycle, as software issues them
    sequence key_pair_on;
        ce && wr_en && addr == OFS_KEY1 && wdata == KEY_A ##1 !wr_en ##1
        ce && wr_en && addr == OFS_KEY2 && wdata == KEY_B;
    endsequence
    sequence key_pair_off;
        ce && wr_en && addr == OFS_KEY1 && wdata == KEY_B ##1 !wr_en ##1
        ce && wr_en && addr == OFS_KEY2 && wdata == KEY_A;
    endsequence

    a_key_toggle_protect: assert property (key_q == KEY_IDLE ##0 key_pair_on ##1 !wr_en ##1 key_pair_off
        |=> protect_q != $past(protect_q, 7)) else $error("key sequence did not toggle protection");
    a_blocked_write_irq: assert property (ce && blocked |=> protection_violation_irq)
        else $error("blocked write raised no request");
    a_blocked_keeps_gear: assert property (ce && blocked && addr == OFS_GEAR
        |=> $stable(src_gear_q)) else $error("protected register changed");
    a_warm_start_busy: assert property (ce && wr_ok && addr == OFS_OSC && wdata[WARM_BIT]
        |=> warm_busy_q) else $error("warm-up did not start");
    a_warm_length_end: assert property ($fell(warm_busy_q)
        |-> $past(warm_cnt_q) + 17'h00001 == $past(warm_target)) else $error("warm-up length wrong");
    a_gear_after_write: assert property (ce && wr_ok && addr == OFS_GEAR && wdata[2:0] <= GEAR_MAX
        ##1 !wr_en ##1 ce && wr_en && addr != OFS_GEAR |=> gear_act_q == $past(src_gear_q[2:0]))
        else $error("gear not in force");
    a_low_source_route: assert property (ce && src_gear_q[SRC_BIT] |=> pre_divider_tick == $past(osc_tick[1]))
        else $error("low clock not routed");
    a_quarter_in_half: assert property (prescaler_tap_quarter |-> prescaler_tap_half)
        else $error("quarter tap outside half tap");
    a_mult_start_lock: assert property (ce && link.start |=> link.lock_busy [*2])
        else $error("lock-up flag not raised");
    a_ext_pin_high: assert property (noise_q[EXT_BIT] |-> osc_output_pin)
        else $error("output pin not high in external mode");
endmodule

// >>> dv/osc_model.sv
module osc_model (
    input  wire logic clock,
    input  wire logic slow,
    output logic      high_osc_in,
    output logic      low_osc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int hcnt = 0;
    int lcnt = 0;
    initial begin
        high_osc_in = 1'b0;
        low_osc_in  = 1'b0;
    end
    // ------------------------------------------------------------
    // Free-running crystals; the slow rate puts x4 at exactly clock/32
    // ------------------------------------------------------------
    always @(posedge clock) begin
        hcnt <= (hcnt + 1 >= (slow ? 64 : 2)) ? 0 : hcnt + 1;
        if (hcnt + 1 >= (slow ? 64 : 2)) high_osc_in <= ~high_osc_in;
        lcnt <= (lcnt == 3) ? 0 : lcnt + 1;
        if (lcnt == 3) low_osc_in <= ~low_osc_in;
    end
endmodule

// >>> dv/test_clock_gear_doubler_protect.sv
module test_clock_gear_doubler_protect
    import clock_gear_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock = 1'b0, srst = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, slow = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
    logic       hi, lo, sys_en, pre, half, quar, hen, len, hdrv, ldrv, pin, irq, h1, h2;
    int         n_mismatch = 0, n_compared = 0, seed = 32'h69e8, n, k;
    always #10 clock = ~clock;
    // Two-flop copy of the high crystal, to predict the idle output pin
    always @(posedge clock) {h2, h1} <= {h1, hi};
    osc_model i_osc_model (.clock(clock), .slow(slow), .high_osc_in(hi), .low_osc_in(lo));
    clock_gear_doubler_protect i_clock_gear_doubler_protect (.clock(clock), .srst(srst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .high_osc_in(hi),
        .low_osc_in(lo), .sys_clock_en(sys_en), .pre_divider_tick(pre), .prescaler_tap_half(half),
        .prescaler_tap_quarter(quar), .high_osc_enable(hen), .low_osc_enable(len),
        .high_osc_drive(hdrv), .low_osc_drive(ldrv), .osc_output_pin(pin), .protection_violation_irq(irq));
    // ------------------------------------------------------------
    // Bus, compare and measure tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_n(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            n_mismatch++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        d = rdata;
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? pre : sel == 1 ? sys_en : sel == 2 ? half : quar;
    endfunction
    // Cycles between two pulses of the chosen output, bounded
    task automatic gap(input int sel, output int c);
        c = 0;
        for (int i = 0; i < 2000 && pick(sel) !== 1'b1; i++) @(negedge clock);
        @(negedge clock);
        c = 1;
        while (c < 2000 && pick(sel) !== 1'b1) begin
            @(negedge clock);
            c++;
        end
    endtask
    // Fast crystal gives one high tick every 4 clocks
    function automatic int exp_gap(input int gear);
        return 4 << gear;
    endfunction
    initial begin
        #1200000;
        n_mismatch++;
        close_out();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        rd(OFS_OSC, r);   cmp8(r, OSC_RST);
        rd(OFS_GEAR, r);  cmp8(r, 8'h04);
        rd(OFS_HALT, r);  cmp8(r, HALT_RST);
        rd(OFS_NOISE, r); cmp8(r, NOISE_RST);
        rd(OFS_MULT, r);  cmp8(r, 8'h00);
        rd(OFS_KEY1, r);  cmp8(r, 8'h00);
        rd(8'h70, r);     cmp8(r, 8'h00);
        cmp8({hen, len, hdrv, ldrv, pin, irq}, {4'hf, ~h2, 1'b0});
        gap(0, n); cmp_n(n, exp_gap(4));
        gap(1, n); cmp_n(n, 2 * exp_gap(4));
        for (int g = 0; g < 4; g++) begin
            wr(OFS_GEAR, g[7:0]);
            wr(OFS_TRIM, 8'h0b);
            gap(0, n); cmp_n(n, exp_gap(g));
            gap(2, n); cmp_n(n, 2 * exp_gap(g));
            gap(3, n); cmp_n(n, 4 * exp_gap(g));
        end
        wr(OFS_GEAR, 8'h08);
        gap(0, n); cmp_n(n, 8);
        wr(OFS_GEAR, 8'h00);
        wr(OFS_OSC, OSC_RST | 8'h02);
        gap(2, n); cmp_n(n, 128);
        gap(3, n); cmp_n(n, 256);
        wr(OFS_OSC, OSC_RST);
        repeat (4) begin
            k = $random(seed);
            wr(OFS_TRIM, k[7:0]);
            rd(OFS_TRIM, r); cmp8(r, k[7:0]);
        end
        ce <= 1'b0;
        wr(OFS_TRIM, ~k[7:0]);
        ce <= 1'b1;
        rd(OFS_TRIM, r); cmp8(r, k[7:0]);
        wr(OFS_HALT, 8'h1c);
        wr(OFS_OSC, OSC_RST | 8'h04);
        repeat (1800) @(posedge clock);
        rd(OFS_OSC, r); cmp8(r[2], 1'b1);
        repeat (400) @(posedge clock);
        rd(OFS_OSC, r); cmp8(r[2], 1'b0);
        wr(OFS_MULT, 8'h50);
        rd(OFS_MULT, r); cmp8(r, 8'h70);
        repeat (3900) @(posedge clock);
        rd(OFS_MULT, r); cmp8(r[5], 1'b1);
        repeat (400) @(posedge clock);
        rd(OFS_MULT, r); cmp8(r, 8'h50);
        slow <= 1'b1;
        wr(OFS_GEAR, 8'h00);
        wr(OFS_MULT, 8'h90);
        repeat (600) @(posedge clock);
        gap(0, n); cmp_n(n, 32);
        wr(OFS_MULT, 8'hd0);
        repeat (600) @(posedge clock);
        gap(0, n); cmp_n(n, 128);
        wr(OFS_MULT, 8'h00);
        slow <= 1'b0;
        wr(OFS_NOISE, 8'h04);
        repeat (10) @(posedge clock);
        cmp8({hdrv, ldrv, pin}, 3'h1);
        wr(OFS_KEY1, KEY_A); wr(OFS_KEY2, KEY_B);
        wr(OFS_KEY1, KEY_B); wr(OFS_KEY2, KEY_A);
        rd(OFS_NOISE, r); cmp8(r, 8'h84);
        wr(OFS_GEAR, 8'h03);
        k = 0;
        repeat (3) begin
            @(negedge clock);
            k += (irq === 1'b1);
        end
        cmp_n(k, 1);
        rd(OFS_GEAR, r); cmp8(r, 8'h00);
        wr(OFS_KEY1, KEY_A); wr(OFS_KEY2, KEY_B);
        wr(OFS_KEY1, KEY_B); wr(OFS_KEY2, KEY_A);
        rd(OFS_NOISE, r); cmp8(r[7], 1'b0);
        close_out();
    end
endmodule
